/* File: src/fault_hb_defs.svh */
// Register offsets, field positions, reset values and timing counts for the fault heartbeat block
`ifndef FAULT_HB_DEFS_SVH
`define FAULT_HB_DEFS_SVH

`define LINK_CONFIG_OFS 8'h00
`define FO_SELECT_OFS 8'h04
`define SYS_FLAGS_OFS 8'h08
`define LINK_FLAGS_OFS 8'h0c
`define DEV_FLAGS_OFS 8'h10
`define SYS_MASK_OFS 8'h14
`define LINK_MASK_OFS 8'h18
`define DEV_MASK_OFS 8'h1c
`define STATUS_OFS 8'h20

`define CFG_HOST_EN_BIT 0
`define CFG_UPPER_EN_BIT 1
`define CFG_STACK_EN_BIT 2
`define RESET_OCCURRED_FLAG_BIT 0
`define LINK_RATE_BIT 0
`define ST_DET_BIT 0
`define ST_CHAIN_BIT 1
`define GRP_LINK_BIT 6
`define GRP_SYS_BIT 7
`define GRP_DEV_BIT 8
`define GRP_PIN_BIT 9

`define LINK_CONFIG_RST 3'h3
`define FO_SELECT_RST 10'h3ff
`define SYS_FLAGS_RST 8'h01
`define FLAGS_RST 8'h00
`define MASK_RST 8'h00

`define CLK_PERIOD_NS 10
`define INIT_WINDOW_NS 4500
`define INIT_WINDOW_CYC (`INIT_WINDOW_NS / `CLK_PERIOD_NS)
`define INIT_EDGE_LIMIT 3'h4
`define SYNC_BEATS 3'h4
`define SYNC_WAIT_US 400
`define HB_PERIOD_CYC (`SYNC_WAIT_US * 1000 / 4 / `CLK_PERIOD_NS)

`endif

/* File: src/fault_hb_pkg.sv */
// Types shared by the fault heartbeat block
package fault_hb_pkg;
    typedef enum logic [1:0] {HB_HOLD, HB_SYNC, HB_RUN} hb_state_t;
endpackage : fault_hb_pkg

/* File: src/stack_fault_heartbeat.sv */
// Fault sensing, heartbeat generation and upper heartbeat watch for one stacked monitor
// How it works
// - Send low-duty heartbeat pulses only while no enabled unmasked fault exists.
// - A set fault flag in a selected group stops the heartbeat; only the startup rate error and the wake event set flags despite masks.
// - A mask blocks future flag setting only; set flags stay set.
// - Unmasked fault events set their matching bit in the fault flag registers.
// - Heartbeat timing comes from the local clock, never from the upper tone.
// - Internal faults pull the fault output low only for selected groups.
// - Lost upper heartbeat reaches the fault output only with upper enable set.
// - Faults assert the fault output only when host port enable is set.
// - Fault output held low during reset and shutdown.
// - One fault-present term stops the tone and, with host port enable set, asserts the output.
// - Heartbeat waits for reset flag clear, then four upper beats when linked.
// - Watch the upper receiver so faults ripple down the stack.
// - With upper enable, missing falling edges set chain fault flags.
// - Under-frequency limit tolerates every other upper pulse going missing.
// - Too-frequent upper edges set rate error; clearable after good edges.
// - Self-test, out-of-range sample and monitor faults stop tone and assert output.
// - Rate error cannot be cleared if no further upper edges arrive.
// - More than four edges in the startup window set rate error even if masked.
// - Rate error depends only on this device's own upper receiver.
// - Each output select bit enables one fault group.
`timescale 1ns/100ps
`default_nettype none
`include "fault_hb_defs.svh"

module stack_fault_heartbeat #(
    parameter int unsigned CNT_W = 16,
    parameter int unsigned HB_PERIOD = `HB_PERIOD_CYC,
    parameter int unsigned HB_PULSE = 100,
    parameter int unsigned UF_LIMIT = 25000,
    parameter int unsigned OF_LIMIT = 5000
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Fault sources
    input wire logic [6:0] sys_fault_evt,
    input wire logic [6:0] link_fault_evt,
    input wire logic [7:0] dev_fault_evt,
    input wire logic [6:0] group_fault_in,
    input wire logic wake_evt,
    input wire logic shutdown,
    // Fault link pins
    input wire logic upper_fault_rx,
    output logic lower_fault_tx,
    output logic fault_n
);
    import fault_hb_pkg::*;

    localparam logic [CNT_W-1:0] HB_PERIOD_L = CNT_W'(HB_PERIOD - 1);
    localparam logic [CNT_W-1:0] HB_PULSE_L = CNT_W'(HB_PULSE);
    localparam logic [CNT_W-1:0] UF_LIMIT_L = CNT_W'(UF_LIMIT);
    localparam logic [CNT_W-1:0] OF_LIMIT_L = CNT_W'(OF_LIMIT);
    localparam logic [9:0] INIT_WIN_L = 10'(`INIT_WINDOW_CYC);

    // Reset release
    logic rst_meta_reg;
    logic rst_sync_reg;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end
    wire logic rst_n = rst_sync_reg;

    // Bus access
    logic req;
    logic wr_stb;
    logic [31:0] wmask;
    logic [31:0] wdat;
    logic [7:0] word_adr;
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr_stb = req & wb_we_i;
    assign word_adr = {wb_adr_i[7:2], 2'b00};
    assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wdat = wb_dat_i & wmask;

    // Registers
    logic [2:0] link_config_reg;
    logic [9:0] fo_select_reg;
    logic [7:0] sys_flags_reg;
    logic [7:0] link_flags_reg;
    logic [7:0] dev_flags_reg;
    logic [7:0] sys_mask_reg;
    logic [7:0] link_mask_reg;
    logic [7:0] dev_mask_reg;
    logic chain_det_reg;
    logic chain_fault_reg;

    wire logic host_en = link_config_reg[`CFG_HOST_EN_BIT];
    wire logic upper_en = link_config_reg[`CFG_UPPER_EN_BIT];
    wire logic stack_en = link_config_reg[`CFG_STACK_EN_BIT];

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_config_reg <= `LINK_CONFIG_RST;
            fo_select_reg <= `FO_SELECT_RST;
            sys_mask_reg <= `MASK_RST;
            link_mask_reg <= `MASK_RST;
            dev_mask_reg <= `MASK_RST;
        end else if (wr_stb) begin
            unique case (word_adr)
                `LINK_CONFIG_OFS: link_config_reg <= (link_config_reg & ~wmask[2:0]) | wdat[2:0];
                `FO_SELECT_OFS: fo_select_reg <= (fo_select_reg & ~wmask[9:0]) | wdat[9:0];
                `SYS_MASK_OFS: sys_mask_reg <= (sys_mask_reg & ~wmask[7:0]) | wdat[7:0];
                `LINK_MASK_OFS: link_mask_reg <= (link_mask_reg & ~wmask[7:0]) | wdat[7:0];
                `DEV_MASK_OFS: dev_mask_reg <= (dev_mask_reg & ~wmask[7:0]) | wdat[7:0];
                default: ;
            endcase
        end
    end

    // Write-one-to-clear strobes for each flag register
    logic [7:0] sys_clr;
    logic [7:0] link_clr;
    logic [7:0] dev_clr;
    logic [1:0] st_clr;
    assign sys_clr = (wr_stb && word_adr == `SYS_FLAGS_OFS) ? wdat[7:0] : 8'h00;
    assign link_clr = (wr_stb && word_adr == `LINK_FLAGS_OFS) ? wdat[7:0] : 8'h00;
    assign dev_clr = (wr_stb && word_adr == `DEV_FLAGS_OFS) ? wdat[7:0] : 8'h00;
    assign st_clr = (wr_stb && word_adr == `STATUS_OFS) ? wdat[1:0] : 2'b00;

    // Upper receiver: two-flop synchroniser, then falling-edge detect on the settled copy
    logic rx_meta_reg;
    logic rx_sync_reg;
    logic rx_prev_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rx_meta_reg <= 1'b0;
            rx_sync_reg <= 1'b0;
            rx_prev_reg <= 1'b0;
        end else begin
            rx_meta_reg <= upper_fault_rx;
            rx_sync_reg <= rx_meta_reg;
            rx_prev_reg <= rx_sync_reg;
        end
    end
    logic fall;
    assign fall = rx_prev_reg & ~rx_sync_reg;

    // Gap between falling edges, saturating at the under-frequency limit
    logic [CNT_W-1:0] gap_reg;
    logic seen_edge_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap_reg <= '0;
            seen_edge_reg <= 1'b0;
        end else begin
            if (fall) begin
                gap_reg <= '0;
                seen_edge_reg <= 1'b1;
            end else if (gap_reg != UF_LIMIT_L) begin
                gap_reg <= gap_reg + 1'b1;
            end
        end
    end

    logic too_fast;
    logic good_edge;
    logic under_freq;
    assign too_fast = fall & seen_edge_reg & (gap_reg < OF_LIMIT_L);
    assign good_edge = fall & seen_edge_reg & ~too_fast;
    // Limit spans more than two periods so one lost pulse goes unreported
    assign under_freq = upper_en & (gap_reg == UF_LIMIT_L - 1'b1) & ~fall;

    // Rate error may only be cleared after a good edge follows it
    logic rate_ok_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rate_ok_reg <= 1'b1;
        end else if (too_fast) begin
            rate_ok_reg <= 1'b0;
        end else if (good_edge) begin
            rate_ok_reg <= 1'b1;
        end
    end

    // Startup window counting upper edges regardless of masking
    logic [9:0] init_cnt_reg;
    logic [2:0] init_edges_reg;
    logic in_init;
    logic init_err;
    assign in_init = init_cnt_reg != INIT_WIN_L;
    assign init_err = in_init & fall & (init_edges_reg == `INIT_EDGE_LIMIT);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            init_cnt_reg <= '0;
            init_edges_reg <= '0;
        end else begin
            if (in_init) begin
                init_cnt_reg <= init_cnt_reg + 1'b1;
            end
            if (in_init && fall && init_edges_reg != `INIT_EDGE_LIMIT) begin
                init_edges_reg <= init_edges_reg + 1'b1;
            end
        end
    end

    // Heartbeat start sequence
    hb_state_t hb_state_reg;
    logic [2:0] beats_reg;
    logic sync_done;
    assign sync_done = (hb_state_reg == HB_SYNC) & good_edge & (beats_reg == `SYNC_BEATS - 3'h1);
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hb_state_reg <= HB_HOLD;
            beats_reg <= '0;
        end else begin
            unique case (hb_state_reg)
                HB_HOLD: begin
                    beats_reg <= '0;
                    if (!sys_flags_reg[`RESET_OCCURRED_FLAG_BIT]) begin
                        hb_state_reg <= stack_en ? HB_SYNC : HB_RUN;
                    end
                end
                HB_SYNC: begin
                    if (sys_flags_reg[`RESET_OCCURRED_FLAG_BIT]) begin
                        hb_state_reg <= HB_HOLD;
                    end else if (sync_done) begin
                        hb_state_reg <= HB_RUN;
                    end else if (good_edge) begin
                        beats_reg <= beats_reg + 3'h1;
                    end
                end
                HB_RUN: begin
                    if (sys_flags_reg[`RESET_OCCURRED_FLAG_BIT]) begin
                        hb_state_reg <= HB_HOLD;
                    end
                end
            endcase
        end
    end

    // Fault flags: set wins over a clear in the same cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sys_flags_reg <= `SYS_FLAGS_RST;
        end else begin
            sys_flags_reg <= (sys_flags_reg & ~sys_clr) | ({sys_fault_evt, 1'b0} & ~sys_mask_reg)
                | {7'h00, wake_evt};
        end
    end

    logic [7:0] link_set;
    assign link_set = ({link_fault_evt, too_fast} & ~link_mask_reg) | {7'h00, init_err};
    logic [7:0] link_clr_ok;
    assign link_clr_ok = {link_clr[7:1], link_clr[`LINK_RATE_BIT] & rate_ok_reg};
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            link_flags_reg <= `FLAGS_RST;
        end else begin
            link_flags_reg <= (link_flags_reg & ~link_clr_ok) | link_set;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            dev_flags_reg <= `FLAGS_RST;
        end else begin
            dev_flags_reg <= (dev_flags_reg & ~dev_clr) | (dev_fault_evt & ~dev_mask_reg);
        end
    end

    // Chain flags; the startup sequence clears the chain fault once four beats arrive
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chain_det_reg <= 1'b0;
            chain_fault_reg <= 1'b0;
        end else begin
            chain_det_reg <= (chain_det_reg & ~st_clr[`ST_DET_BIT]) | under_freq;
            chain_fault_reg <= (chain_fault_reg & ~st_clr[`ST_CHAIN_BIT] & ~sync_done) | under_freq;
        end
    end

    // Shared fault-present term
    logic [9:0] group_active;
    logic fault_present;
    always_comb begin
        group_active = {group_fault_in[6], |dev_flags_reg, |sys_flags_reg, |link_flags_reg, group_fault_in[5:0]};
    end
    assign fault_present = (|(group_active & fo_select_reg))
        | (upper_en & chain_fault_reg);

    // Heartbeat generator on the local clock only
    logic [CNT_W-1:0] hb_cnt_reg;
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hb_cnt_reg <= '0;
        end else if (hb_cnt_reg == HB_PERIOD_L) begin
            hb_cnt_reg <= '0;
        end else begin
            hb_cnt_reg <= hb_cnt_reg + 1'b1;
        end
    end

    // Both pins register the same fault term on the same edge; fault_n also needs host_en
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            lower_fault_tx <= 1'b0;
            fault_n <= 1'b0;
        end else begin
            lower_fault_tx <= (hb_state_reg == HB_RUN) & ~fault_present & ~shutdown
                & (hb_cnt_reg < HB_PULSE_L);
            fault_n <= ~(host_en & fault_present) & ~shutdown;
        end
    end

    // Read data and acknowledge; unmapped words read zero and writes there are dropped
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        unique case (word_adr)
            `LINK_CONFIG_OFS: rd_mux[2:0] = link_config_reg;
            `FO_SELECT_OFS: rd_mux[9:0] = fo_select_reg;
            `SYS_FLAGS_OFS: rd_mux[7:0] = sys_flags_reg;
            `LINK_FLAGS_OFS: rd_mux[7:0] = link_flags_reg;
            `DEV_FLAGS_OFS: rd_mux[7:0] = dev_flags_reg;
            `SYS_MASK_OFS: rd_mux[7:0] = sys_mask_reg;
            `LINK_MASK_OFS: rd_mux[7:0] = link_mask_reg;
            `DEV_MASK_OFS: rd_mux[7:0] = dev_mask_reg;
            `STATUS_OFS: rd_mux[4:0] = {rate_ok_reg, fault_present, lower_fault_tx | (hb_state_reg == HB_RUN),
                chain_fault_reg, chain_det_reg};
            default: ;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_mux;
            end
        end
    end

endmodule : stack_fault_heartbeat
`default_nettype wire

/* File: tb/stack_fault_heartbeat_assertions.sv */
// Port-level checks for the fault heartbeat block
`timescale 1ns/100ps
`default_nettype none
module stack_fault_heartbeat_checker #(
    parameter int unsigned HB_PULSE = 100
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rstn,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Fault pins
    input wire logic shutdown,
    input wire logic lower_fault_tx,
    input wire logic fault_n
);
    int unsigned hi_reg;
    default clocking @(posedge mclk);
    endclocking
    default disable iff (!rstn);
    // Length of the current tone pulse, too long for an unrolled repetition
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hi_reg <= 0;
        end else begin
            hi_reg <= lower_fault_tx ? hi_reg + 1 : 0;
        end
    end
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_boot;
        (!lower_fault_tx && !fault_n)[*3] ##1 !lower_fault_tx[*5];
    endsequence
    sequence s_gap;
        !lower_fault_tx[*8];
    endsequence
    a_ack_latency: assert property (s_req |=> wb_ack_o) else $error("ack late");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_read_hold: assert property (!wb_ack_o |-> $stable(wb_dat_o)) else $error("read data moved");
    a_shut_fault: assert property (shutdown |=> !fault_n) else $error("fault_n high in shutdown");
    a_shut_tone: assert property (shutdown |=> !lower_fault_tx) else $error("tone in shutdown");
    a_tone_no_fault: assert property (lower_fault_tx |-> fault_n) else $error("tone with fault");
    a_pulse_width: assert property (hi_reg <= HB_PULSE) else $error("pulse too long");
    a_pulse_gap: assert property ($fell(lower_fault_tx) |-> s_gap) else $error("duty too high");
    a_boot_quiet: assert property ($rose(rstn) |-> s_boot) else $error("tone before start");
endmodule : stack_fault_heartbeat_checker

bind stack_fault_heartbeat stack_fault_heartbeat_checker #(.HB_PULSE(HB_PULSE)) i_chk (.mclk(mclk), .rstn(rstn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .shutdown(shutdown), .lower_fault_tx(lower_fault_tx), .fault_n(fault_n));
`default_nettype wire

/* File: tb/upper_tone_model.sv */
// Heartbeat source standing in for the monitor above
`timescale 1ns/100ps
`default_nettype none
module upper_tone_model (
    // Clock
    input wire logic mclk,
    // Control
    input wire logic run,
    input wire logic skip_alt,
    input wire logic [7:0] period,
    // Tone toward the block
    output logic tone
);
    logic [7:0] cnt_reg = 8'h00;
    logic odd_reg = 1'h0;
    initial tone = 1'h0;
    // A stopped neighbour leaves the line low, which is what a lost tone looks like
    always @(posedge mclk) begin
        cnt_reg <= (cnt_reg + 8'h01 >= period) ? 8'h00 : cnt_reg + 8'h01;
        if (cnt_reg == 8'h00) begin
            odd_reg <= !odd_reg;
        end
        tone <= run && cnt_reg < 8'h05 && !(skip_alt && odd_reg);
    end
endmodule : upper_tone_model
`default_nettype wire

/* File: tb/stack_fault_heartbeat_bench.sv */
// Self-checking bench for the fault heartbeat block
`timescale 1ns/100ps
`default_nettype none
module stack_fault_heartbeat_bench;
    logic mclk = 1'h0, rstn = 1'h0, cyc = 1'h0, stb = 1'h0, we = 1'h0, ack, shut = 1'h0, wake = 1'h0;
    logic run = 1'h1, skip = 1'h0, tone, tx, fn;
    logic [7:0] adr = 8'h00, per = 8'h78;
    logic [31:0] wdat = 32'h0, rdat;
    logic [6:0] sev = 7'h0, lev = 7'h0, grp = 7'h0;
    logic [7:0] dev = 8'h0;
    int err_total = 0, n_compared = 0;
    always #5 mclk = !mclk;
    stack_fault_heartbeat #(.HB_PERIOD(100), .HB_PULSE(5), .UF_LIMIT(250), .OF_LIMIT(50)) i_dut (.mclk(mclk),
        .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .sys_fault_evt(sev), .link_fault_evt(lev),
        .dev_fault_evt(dev), .group_fault_in(grp), .wake_evt(wake), .shutdown(shut),
        .upper_fault_rx(tone), .lower_fault_tx(tx), .fault_n(fn));
    upper_tone_model i_above (.mclk(mclk), .run(run), .skip_alt(skip), .period(per), .tone(tone));
    task automatic end_sim;
        if (err_total == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge mclk);
    endtask : idle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        wdat <= d;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge mclk);
        end while (ack !== 1'h1);
        chk(ack, 1'h1);
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask : wb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, q);
        chk(q & m, exp);
    endtask : rdc
    task automatic wait_fn(input logic v);
        repeat (20) begin
            @(posedge mclk);
            if (fn === v) break;
        end
        chk(fn, v);
    endtask : wait_fn
    // Event in one cycle; the pins answer one edge after it is sampled
    task automatic hit(input logic [6:0] s, input logic [6:0] l, input logic [7:0] d);
        @(posedge mclk);
        sev <= s;
        lev <= l;
        dev <= d;
        @(posedge mclk);
        sev <= 7'h0;
        lev <= 7'h0;
        dev <= 8'h0;
        idle(3);
    endtask : hit
    task automatic t_reset;
        rdc(8'h00, 32'hffffffff, 32'h3);
        rdc(8'h04, 32'hffffffff, 32'h3ff);
        rdc(8'h08, 32'hffffffff, 32'h1);
        rdc(8'h18, 32'hffffffff, 32'h0);
        rdc(8'h24, 32'hffffffff, 32'h0);
        idle(500);
        wr(8'h08, 32'h1);
        repeat (200) begin
            @(posedge mclk);
            if (tx === 1'h1) break;
        end
        chk(tx, 1'h1);
        chk(fn, 1'h1);
    endtask : t_reset
    task automatic t_upper;
        skip <= 1'h1;
        idle(600);
        rdc(8'h20, 32'h3, 32'h0);
        run <= 1'h0;
        idle(300);
        rdc(8'h20, 32'h3, 32'h3);
        chk({fn, tx}, 2'b00);
        run <= 1'h1;
        skip <= 1'h0;
        idle(300);
        wr(8'h20, 32'h3);
        wait_fn(1'h1);
        wr(8'h00, 32'h1);
        run <= 1'h0;
        idle(300);
        chk(fn, 1'h1);
        run <= 1'h1;
        idle(300);
        wr(8'h00, 32'h3);
    endtask : t_upper
    task automatic t_rate;
        per <= 8'h1e;
        idle(200);
        rdc(8'h0c, 32'h1, 32'h1);
        wr(8'h0c, 32'h1);
        rdc(8'h0c, 32'h1, 32'h1);
        chk(fn, 1'h0);
        rdc(8'h20, 32'h18, 32'h8);
        per <= 8'h78;
        idle(300);
        wr(8'h0c, 32'h1);
        rdc(8'h0c, 32'h1, 32'h0);
        wait_fn(1'h1);
    endtask : t_rate
    task automatic t_mask;
        hit(7'h1, 7'h0, 8'h0);
        chk({fn, tx}, 2'b00);
        rdc(8'h08, 32'hff, 32'h2);
        wr(8'h14, 32'h2);
        rdc(8'h08, 32'hff, 32'h2);
        wr(8'h08, 32'h2);
        wait_fn(1'h1);
        hit(7'h1, 7'h0, 8'h0);
        chk(fn, 1'h1);
        rdc(8'h08, 32'hff, 32'h0);
        wr(8'h14, 32'h0);
    endtask : t_mask
    task automatic t_groups;
        wr(8'h04, 32'h37f);
        hit(7'h1, 7'h0, 8'h0);
        chk(fn, 1'h1);
        wr(8'h08, 32'h2);
        wr(8'h04, 32'h3ff);
        wr(8'h00, 32'h2);
        hit(7'h0, 7'h0, 8'h1);
        chk(fn, 1'h1);
        wr(8'h10, 32'h1);
        wr(8'h00, 32'h3);
        hit(7'h0, 7'h2, 8'h0);
        chk(fn, 1'h0);
        rdc(8'h0c, 32'hff, 32'h4);
        wr(8'h0c, 32'h4);
        wait_fn(1'h1);
        grp <= 7'h1;
        idle(3);
        chk(fn, 1'h0);
        grp <= 7'h0;
        wait_fn(1'h1);
    endtask : t_groups
    task automatic t_power;
        shut <= 1'h1;
        idle(2);
        chk({fn, tx}, 2'b00);
        shut <= 1'h0;
        wait_fn(1'h1);
        wake <= 1'h1;
        @(posedge mclk);
        wake <= 1'h0;
        idle(3);
        chk(fn, 1'h0);
        rdc(8'h08, 32'h1, 32'h1);
        wr(8'h00, 32'h7);
        run <= 1'h0;
        idle(300);
        run <= 1'h1;
        wr(8'h08, 32'h1);
        idle(150);
        chk({fn, tx}, 2'b00);
        idle(450);
        rdc(8'h20, 32'h7, 32'h5);
        wait_fn(1'h1);
    endtask : t_power
    // Fast upper edges right after a mid-run reset, with the rate error masked early
    task automatic t_init;
        per <= 8'h1e;
        @(posedge mclk);
        rstn <= 1'h0;
        idle(2);
        chk({fn, tx}, 2'b00);
        rstn <= 1'h1;
        idle(2);
        wr(8'h18, 32'h1);
        idle(300);
        rdc(8'h0c, 32'h1, 32'h1);
    endtask : t_init
    initial begin
        @(posedge mclk);
        @(posedge mclk);
        chk({fn, tx}, 2'b00);
        rstn <= 1'h1;
        idle(2);
        t_reset();
        t_upper();
        t_rate();
        t_mask();
        t_groups();
        t_power();
        t_init();
        end_sim();
    end
    // Whole run is a little over four thousand cycles
    initial begin
        #200000;
        err_total++;
        end_sim();
    end
endmodule : stack_fault_heartbeat_bench
`default_nettype wire
